/* File: src/sft_pkg.sv */
/*
  Shared constants and types for the serial transmit framer: register offsets,
  field layouts, reset values, frame modes, stop lengths and transmit states.
  Assumes a single 100 MHz peripheral bus clock and a 32-bit AHB-Lite bus.
*/
package sft_pkg;

  // clock of the block, for reference by the bench
  localparam int unsigned CLK_PERIOD_NS = 10;

  // transmit queue shape and flag thresholds
  localparam int unsigned TXQ_DEPTH    = 16;
  localparam int unsigned TXQ_WIDTH    = 9;
  localparam int unsigned TXQ_LOW_MARK = 8;

  // baud generator
  localparam int unsigned BAUD_WIDTH  = 16;
  localparam logic [3:0]  BIT_TICKS_M1 = 4'hF;   // sixteen ticks per bit, minus one

  // register byte offsets (low address byte only is decoded)
  localparam logic [7:0] ADDR_BAUD  = 8'h00;
  localparam logic [7:0] ADDR_TXW   = 8'h04;
  localparam logic [7:0] ADDR_CTRL  = 8'h08;
  localparam logic [7:0] ADDR_STAT  = 8'h0C;
  localparam logic [7:0] ADDR_FLUSH = 8'h10;

  // frame format field codes
  localparam logic [2:0] MODE_8D  = 3'h1;
  localparam logic [2:0] MODE_7DP = 3'h3;
  localparam logic [2:0] MODE_9D  = 3'h4;
  localparam logic [2:0] MODE_8DW = 3'h5;
  localparam logic [2:0] MODE_8DP = 3'h7;

  // stop length codes and their length in oversampling ticks, minus one
  localparam logic [1:0] STOP_HALF     = 2'h0;
  localparam logic [1:0] STOP_ONE      = 2'h1;
  localparam logic [1:0] STOP_ONE_HALF = 2'h2;
  localparam logic [5:0] STOP_TICKS_HALF     = 6'h07;
  localparam logic [5:0] STOP_TICKS_ONE      = 6'h0F;
  localparam logic [5:0] STOP_TICKS_ONE_HALF = 6'h17;
  localparam logic [5:0] STOP_TICKS_TWO      = 6'h1F;

  // serial_control_word layout, bit 9 down to bit 0
  typedef struct packed {
    logic       fifo_en;
    logic       receive_accept_enable;
    logic       internal_echo_test;
    logic       run;
    logic       odd_parity_select;
    logic [1:0] stop;
    logic [2:0] mode;
  } sft_ctrl_type;

  // serial_status_word layout, bit 7 down to bit 0
  typedef struct packed {
    logic [4:0] level;
    logic       tx_shifter_idle_flag;
    logic       tx_queue_low_flag;
    logic       tx_queue_full_flag;
  } sft_status_type;

  localparam logic [9:0]  CTRL_RESET = 10'h000;
  localparam logic [15:0] BAUD_RESET = 16'h0001;

  // transmitter states, one-hot
  typedef enum logic [3:0] {
    TX_IDLE  = 4'b0001,
    TX_START = 4'b0010,
    TX_DATA  = 4'b0100,
    TX_STOP  = 4'b1000
  } sft_tx_state_type;

endpackage

/* File: src/sft_baud.sv */
/*
  Oversampling tick generator: one tick every divisor clocks, which gives
  sixteen ticks per bit. Assumes the divisor and run bit come from registers
  in the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module sft_baud
  import sft_pkg::*;
#(
  parameter int unsigned WIDTH = BAUD_WIDTH
) (
  // clock, reset, enable
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  // control
  input  wire logic             run_i,
  input  wire logic [WIDTH-1:0] divisor_i,
  // tick out
  output logic                  tick_o
);

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic             tick;
  } sft_baud_state_type;

  sft_baud_state_type st_reg;
  sft_baud_state_type st_next;

  // count down, reload on expiry; divisor 0 behaves like 1
  always_comb begin
    st_next      = st_reg;
    st_next.tick = 1'b0;
    if (run_i) begin
      if (st_reg.cnt <= WIDTH'(1)) begin
        st_next.tick = 1'b1;
        st_next.cnt  = divisor_i;
      end else begin
        st_next.cnt = st_reg.cnt - WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  assign tick_o = st_reg.tick;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_BAUD_FROZEN: assert property (ce_i && !run_i |=> !tick_o)
    else $error("tick while run bit clear");
  AST_BAUD_SPACING: assert property (ce_i && tick_o && run_i && divisor_i > WIDTH'(1) |=> !tick_o)
    else $error("ticks closer than the divisor");

endmodule // sft_baud
`default_nettype wire

/* File: src/sft_txq.sv */
/*
  Transmit queue: a circular buffer with push, pop and flush. In one-deep mode
  it counts as full at one entry and a write replaces the stored entry.
  Assumes push, pop and flush come from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module sft_txq
  import sft_pkg::*;
#(
  parameter int unsigned WIDTH    = TXQ_WIDTH,
  parameter int unsigned DEPTH    = TXQ_DEPTH,
  parameter int unsigned LOW_MARK = TXQ_LOW_MARK,
  localparam int unsigned AW      = $clog2(DEPTH),
  localparam int unsigned CW      = $clog2(DEPTH + 1)
) (
  // clock, reset, enable
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  // requests
  input  wire logic             push_i,
  input  wire logic [WIDTH-1:0] data_i,
  input  wire logic             pop_i,
  input  wire logic             flush_i,
  input  wire logic             fifo_en_i,
  // state
  output logic      [WIDTH-1:0] head_o,
  output logic      [CW-1:0]    count_o,
  output logic                  full_o,
  output logic                  low_o
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [CW-1:0]               cnt;
  } sft_txq_state_type;

  sft_txq_state_type st_reg;
  sft_txq_state_type st_next;
  logic              do_pop;
  logic              do_push;

  // flags from the registered count
  assign full_o  = fifo_en_i ? (st_reg.cnt == CW'(DEPTH)) : (st_reg.cnt != '0);
  assign low_o   = fifo_en_i ? (st_reg.cnt <= CW'(LOW_MARK)) : (st_reg.cnt == '0);
  assign count_o = st_reg.cnt;
  assign head_o  = st_reg.mem[st_reg.rd];
  assign do_pop  = pop_i && (st_reg.cnt != '0);
  assign do_push = push_i && (!full_o || do_pop);

  // flush wins over a push or pop in the same cycle
  always_comb begin
    st_next = st_reg;
    if (flush_i) begin
      st_next.wr  = '0;
      st_next.rd  = '0;
      st_next.cnt = '0;
    end else begin
      if (do_pop) begin
        st_next.rd = AW'(st_reg.rd + 1'b1);
      end
      if (do_push) begin
        st_next.mem[st_reg.wr] = data_i;
        st_next.wr             = AW'(st_reg.wr + 1'b1);
      end else if (push_i && !fifo_en_i) begin
        st_next.mem[st_reg.rd] = data_i;
      end
      // a full write in queued mode falls through untouched
      if (do_push && !do_pop) begin
        st_next.cnt = CW'(st_reg.cnt + 1'b1);
      end else if (do_pop && !do_push) begin
        st_next.cnt = CW'(st_reg.cnt - 1'b1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_Q_FULL_KEEPS: assert property (ce_i && fifo_en_i && full_o && push_i && !pop_i && !flush_i
                                     |=> $stable(st_reg.wr) && $stable(st_reg.cnt))
    else $error("write into full queue changed it");
  AST_Q_FLUSH: assert property (ce_i && flush_i |=> count_o == '0)
    else $error("flush left entries behind");
  AST_Q_PUSH: assert property (ce_i && fifo_en_i && push_i && !full_o && !pop_i && !flush_i
                               |=> count_o == $past(count_o) + 1'b1)
    else $error("push did not add one entry");
  COV_Q_FULL: cover property (fifo_en_i && full_o);

endmodule // sft_txq
`default_nettype wire

/* File: src/sft_framer.sv */
/*
  Transmit side and frame formatting of an asynchronous serial port, reached
  over an AHB-Lite slave. Holds the control, baud and status registers, the
  transmit queue, the 9-bit shifter, loop-back routing and the wake-up filter
  in front of the receive queue. Assumes a receiver on the same clock that
  takes the serial input, the oversampling tick and the control word from here.
*/
// The register addresses and register access over AHB-Lite are this design's own decisions.
// Behaviour
// - receiver gets the same control word, tick and a serial input from here
// - format 100 nine data; 111 eight plus parity; 101 eight plus wake bit
// - even parity is the data xor; odd parity is its inverse
// - in wake-up mode only frames with ninth bit set reach the receiver queue
// - a write to the transmit port pushes one 9-bit entry of sixteen while the queue has room
// - queued mode: full flag at sixteen entries, extra writes lose nothing stored
// - one-deep mode: full at one entry, a write replaces it
// - low flag at eight or fewer entries, or when empty in one-deep mode
// - any write to the flush register empties the queue at once
// - with run set, idle shifter loads as soon as the queue holds an entry; sending starts next tick, or when stop bits in progress end
// - entering stop bits reloads the shifter if queued data waits
// - idle flag shows the shifter holds no character
// - loop-back feeds the shifter output to the receiver input
// - bit timing comes from a 16-bit reload divisor
// - ticks at sixteen per bit, only while run is set
// - baud is bus clock over sixteen times the unsigned divisor
`timescale 1ns/1ps
`default_nettype none
module sft_framer
  import sft_pkg::*;
(
  // clock, reset, enable
  input  wire logic                  CLK_SYS_I,
  input  wire logic                  RST_I,
  input  wire logic                  CE_I,
  // ahb-lite slave
  input  wire logic                  HSEL_I,
  input  wire logic [31:0]           HADDR_I,
  input  wire logic [1:0]            HTRANS_I,
  input  wire logic                  HWRITE_I,
  input  wire logic [2:0]            HSIZE_I,
  input  wire logic [31:0]           HWDATA_I,
  input  wire logic                  HREADY_I,
  output logic      [31:0]           HRDATA_O,
  output logic                       HREADYOUT_O,
  output logic                       HRESP_O,
  // serial pins
  output logic                       TXD_O,
  input  wire logic                  RXD_I,
  // receiver side, same clock
  output logic                       RX_SERIAL_O,
  output logic                       RX_TICK_O,
  output sft_pkg::sft_ctrl_type      RX_CTRL_O,
  input  wire logic                  RX_FRAME_VALID_I,
  input  wire logic [8:0]            RX_FRAME_DATA_I,
  output logic                       RX_ACCEPT_O,
  output logic      [8:0]            RX_DATA_O
);

  typedef struct packed {
    logic             dp_valid;
    logic             dp_write;
    logic [7:0]       dp_addr;
    logic [31:0]      hrdata;
    logic             ready;
    logic             resp;
    sft_ctrl_type     ctrl;
    logic [15:0]      baud;
    sft_tx_state_type txs;
    logic [8:0]       shift;
    logic [3:0]       frame_bits;
    logic [3:0]       bit_left;
    logic [5:0]       tick_left;
    logic             busy;
    logic             txd;
    logic             rx_meta;
    logic             rx_sync;
    logic             rx_serial;
    logic             rx_accept;
    logic [8:0]       rx_data;
  } sft_top_state_type;

  sft_top_state_type st_reg;
  sft_top_state_type st_next;

  logic           tick;
  logic           q_push;
  logic           q_pop;
  logic           q_flush;
  logic [8:0]     q_head;
  logic [4:0]     q_count;
  logic           q_full;
  logic           q_low;
  logic           q_ready;
  logic [8:0]     frame;
  logic [3:0]     frame_len;
  logic [5:0]     stop_ticks;
  logic           parity;
  logic           addr_phase;
  sft_status_type status;

  sft_baud #(
    .WIDTH (BAUD_WIDTH)
  ) u_baud (
    .clk_i     (CLK_SYS_I),
    .rst_i     (RST_I),
    .ce_i      (CE_I),
    .run_i     (st_reg.ctrl.run),
    .divisor_i (st_reg.baud),
    .tick_o    (tick)
  );

  sft_txq #(
    .WIDTH    (TXQ_WIDTH),
    .DEPTH    (TXQ_DEPTH),
    .LOW_MARK (TXQ_LOW_MARK)
  ) u_txq (
    .clk_i     (CLK_SYS_I),
    .rst_i     (RST_I),
    .ce_i      (CE_I),
    .push_i    (q_push),
    .data_i    (HWDATA_I[8:0]),
    .pop_i     (q_pop),
    .flush_i   (q_flush),
    .fifo_en_i (st_reg.ctrl.fifo_en),
    .head_o    (q_head),
    .count_o   (q_count),
    .full_o    (q_full),
    .low_o     (q_low)
  );

  // bus decode; writes act in the data phase, reads are fetched at the address phase
  assign addr_phase = HSEL_I && HREADY_I && HTRANS_I[1];
  assign q_push     = st_reg.dp_valid && st_reg.dp_write && (st_reg.dp_addr == ADDR_TXW);
  assign q_flush    = st_reg.dp_valid && st_reg.dp_write && (st_reg.dp_addr == ADDR_FLUSH);
  assign q_ready    = (q_count != '0) && !q_flush;

  // status word as software sees it
  assign status.level                = q_count;
  assign status.tx_shifter_idle_flag = !st_reg.busy;
  assign status.tx_queue_low_flag    = q_low;
  assign status.tx_queue_full_flag   = q_full;

  // frame image of the queue head; parity is the data xor, flipped for odd
  always_comb begin
    parity    = 1'b0;
    frame     = {1'b0, q_head[7:0]};
    frame_len = 4'h8;
    unique case (st_reg.ctrl.mode)
      MODE_7DP: begin
        parity    = (^q_head[6:0]) ^ st_reg.ctrl.odd_parity_select;
        frame     = {1'b0, parity, q_head[6:0]};
      end
      MODE_8DP: begin
        parity    = (^q_head[7:0]) ^ st_reg.ctrl.odd_parity_select;
        frame     = {parity, q_head[7:0]};
        frame_len = 4'h9;
      end
      MODE_9D, MODE_8DW: begin
        frame     = q_head;
        frame_len = 4'h9;
      end
      default: begin
        frame     = {1'b0, q_head[7:0]};
        frame_len = 4'h8;
      end
    endcase
  end

  // stop period length in ticks
  always_comb begin
    unique case (st_reg.ctrl.stop)
      STOP_HALF:     stop_ticks = STOP_TICKS_HALF;
      STOP_ONE:      stop_ticks = STOP_TICKS_ONE;
      STOP_ONE_HALF: stop_ticks = STOP_TICKS_ONE_HALF;
      default:       stop_ticks = STOP_TICKS_TWO;
    endcase
  end

  // register file, transmitter and receive-side helpers
  always_comb begin
    st_next          = st_reg;
    q_pop            = 1'b0;
    st_next.dp_valid = addr_phase;
    st_next.ready    = 1'b1;
    st_next.resp     = 1'b0;
    if (addr_phase) begin
      st_next.dp_write = HWRITE_I;
      st_next.dp_addr  = HADDR_I[7:0];
      if (!HWRITE_I) begin
        unique case (HADDR_I[7:0])
          ADDR_BAUD: st_next.hrdata = {16'h0000, st_reg.baud};
          ADDR_CTRL: st_next.hrdata = {22'h000000, st_reg.ctrl};
          ADDR_STAT: st_next.hrdata = {24'h000000, status};
          default:   st_next.hrdata = 32'h00000000;
        endcase
      end
    end
    if (st_reg.dp_valid && st_reg.dp_write) begin
      if (st_reg.dp_addr == ADDR_BAUD) begin
        st_next.baud = HWDATA_I[15:0];
      end
      if (st_reg.dp_addr == ADDR_CTRL) begin
        st_next.ctrl = sft_ctrl_type'(HWDATA_I[9:0]);
      end
    end
    // transmitter moves only while run is set
    if (st_reg.ctrl.run) begin
      if (!st_reg.busy && q_ready) begin
        q_pop              = 1'b1;
        st_next.busy       = 1'b1;
        st_next.shift      = frame;
        st_next.frame_bits = frame_len;
      end
      if (tick) begin
        unique case (st_reg.txs)
          TX_IDLE: begin
            if (st_reg.busy) begin
              st_next.txs       = TX_START;
              st_next.txd       = 1'b0;
              st_next.tick_left = {2'b00, BIT_TICKS_M1};
            end
          end
          TX_START: begin
            if (st_reg.tick_left == '0) begin
              st_next.txs       = TX_DATA;
              st_next.txd       = st_reg.shift[0];
              st_next.shift     = {1'b0, st_reg.shift[8:1]};
              st_next.bit_left  = st_reg.frame_bits - 4'h1;
              st_next.tick_left = {2'b00, BIT_TICKS_M1};
            end else begin
              st_next.tick_left = st_reg.tick_left - 6'h01;
            end
          end
          TX_DATA: begin
            if (st_reg.tick_left != '0) begin
              st_next.tick_left = st_reg.tick_left - 6'h01;
            end else if (st_reg.bit_left == '0) begin
              st_next.txs       = TX_STOP;
              st_next.txd       = 1'b1;
              st_next.tick_left = stop_ticks;
              st_next.busy      = q_ready;
              if (q_ready) begin
                q_pop              = 1'b1;
                st_next.shift      = frame;
                st_next.frame_bits = frame_len;
              end
            end else begin
              st_next.txd       = st_reg.shift[0];
              st_next.shift     = {1'b0, st_reg.shift[8:1]};
              st_next.bit_left  = st_reg.bit_left - 4'h1;
              st_next.tick_left = {2'b00, BIT_TICKS_M1};
            end
          end
          TX_STOP: begin
            if (st_reg.tick_left != '0) begin
              st_next.tick_left = st_reg.tick_left - 6'h01;
            end else if (st_reg.busy) begin
              st_next.txs       = TX_START;
              st_next.txd       = 1'b0;
              st_next.tick_left = {2'b00, BIT_TICKS_M1};
            end else begin
              st_next.txs = TX_IDLE;
            end
          end
        endcase
      end
    end
    // pin input passes two flops before use
    st_next.rx_meta   = RXD_I;
    st_next.rx_sync   = st_reg.rx_meta;
    st_next.rx_serial = st_reg.ctrl.internal_echo_test ? st_reg.txd : st_reg.rx_sync;
    // wake-up filter in front of the receive queue
    st_next.rx_accept = RX_FRAME_VALID_I && st_reg.ctrl.receive_accept_enable &&
                        ((st_reg.ctrl.mode != MODE_8DW) || RX_FRAME_DATA_I[8]);
    if (RX_FRAME_VALID_I) begin
      st_next.rx_data = RX_FRAME_DATA_I;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      st_reg       <= '0;
      st_reg.txs   <= TX_IDLE;
      st_reg.txd   <= 1'b1;
      st_reg.ready <= 1'b1;
      st_reg.ctrl  <= sft_ctrl_type'(CTRL_RESET);
      st_reg.baud  <= BAUD_RESET;
    end else if (CE_I) begin
      st_reg <= st_next;
    end
  end

  // every output straight from a state register, RX_TICK_O from the baud generator's
  assign HRDATA_O    = st_reg.hrdata;
  assign HREADYOUT_O = st_reg.ready;
  assign HRESP_O     = st_reg.resp;
  assign TXD_O       = st_reg.txd;
  assign RX_SERIAL_O = st_reg.rx_serial;
  assign RX_TICK_O   = tick;
  assign RX_CTRL_O   = st_reg.ctrl;
  assign RX_ACCEPT_O = st_reg.rx_accept;
  assign RX_DATA_O   = st_reg.rx_data;

  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);

  AST_IDLE_HIGH: assert property (st_reg.txs == TX_IDLE |-> TXD_O)
    else $error("line not high while idle");
  AST_START_LOW: assert property (st_reg.txs == TX_START |-> !TXD_O)
    else $error("start bit not low");
  AST_STOP_HIGH: assert property (st_reg.txs == TX_STOP |-> TXD_O)
    else $error("stop bit not high");
  AST_LOAD_NOW: assert property (CE_I && st_reg.ctrl.run && !st_reg.busy && q_ready |=> st_reg.busy)
    else $error("idle shifter did not load");
  // checked on the loaded shifter, so a wrong parity expression shows up here
  AST_PARITY_7: assert property (CE_I && q_pop && st_reg.ctrl.mode == MODE_7DP
                                 |=> (^st_reg.shift[7:0]) == st_reg.ctrl.odd_parity_select)
    else $error("wrong parity bit");
  AST_RELOAD_STOP: assert property (CE_I && st_reg.ctrl.run && tick && st_reg.txs == TX_DATA
                                    && st_reg.tick_left == '0 && st_reg.bit_left == '0 && q_ready
                                    |=> st_reg.txs == TX_STOP && st_reg.busy)
    else $error("no reload at stop entry");
  AST_ECHO: assert property (CE_I && st_reg.ctrl.internal_echo_test |=> RX_SERIAL_O == $past(st_reg.txd))
    else $error("loop-back not routed");
  AST_WAKE_DROP: assert property (CE_I && RX_FRAME_VALID_I && st_reg.ctrl.mode == MODE_8DW
                                  && !RX_FRAME_DATA_I[8] |=> !RX_ACCEPT_O)
    else $error("data frame passed in wake-up mode");
  AST_IDLE_FLAG: assert property ((st_reg.txs == TX_START || st_reg.txs == TX_DATA)
                                  |-> !status.tx_shifter_idle_flag)
    else $error("start without a loaded shifter");

  COV_BACK_TO_BACK: cover property (st_reg.txs == TX_STOP && st_reg.busy ##1 st_reg.txs == TX_START);
  COV_FLUSH: cover property (q_flush && q_count != '0);
  COV_WAKE_ADDR: cover property (RX_ACCEPT_O && st_reg.ctrl.mode == MODE_8DW);

endmodule // sft_framer
`default_nettype wire

/* File: tb/sft_peer.sv */
/*
  Far-end serial peer: decodes frames from the block's serial output.
  Assumes a fixed bit time in clocks and two stop bits, so ten slots end high.
*/
`timescale 1ns/1ps
`default_nettype none
module sft_peer #(
  parameter int BIT_CLKS = 32
) (
  // clock
  input  wire logic clk_i,
  // serial line
  input  wire logic line_i,
  output logic      line_o
);
  logic [9:0] got[$];
  logic [9:0] w;

  // nothing sent back, so the line rests at idle
  assign line_o = 1'h1;

  // mid-bit sampling avoids the edges where the line moves
  initial begin
    forever begin
      @(negedge line_i);
      repeat (BIT_CLKS / 2) @(posedge clk_i);
      for (int i = 0; i < 10; i++) begin
        repeat (BIT_CLKS) @(posedge clk_i);
        w[i] = line_i;
      end
      got.push_back(w);
    end
  end
endmodule // sft_peer
`default_nettype wire

/* File: tb/async_serial_transmitter_framer_bench.sv */
/*
  Bench for the serial transmit framer: bus master, frame model, verdict.
  Assumes the peer decodes the serial output at a divisor of two.
*/
`timescale 1ns/1ps
`default_nettype none
module async_serial_transmitter_framer_bench;
  import sft_pkg::*;
  logic        CLK_SYS_I = 1'h0, RST_I = 1'h1, CE_I = 1'h1, HSEL_I = 1'h0, HWRITE_I = 1'h0;
  logic        HREADYOUT_O, TXD_O, RXD_I, RX_FRAME_VALID_I = 1'h0, RX_ACCEPT_O, RX_SERIAL_O, RX_TICK_O;
  logic [31:0] HADDR_I = '0, HWDATA_I = '0, HRDATA_O, r, c;
  logic [1:0]  HTRANS_I = 2'h0;
  logic [2:0]  HSIZE_I = 3'h2;
  logic [8:0]  RX_FRAME_DATA_I = '0, d[2], RX_DATA_O;
  logic [2:0]  modes[5] = '{MODE_8D, MODE_7DP, MODE_9D, MODE_8DW, MODE_8DP};
  sft_ctrl_type RX_CTRL_O;
  int          n_errors = 0, num_checks = 0, nt;

  // clock
  always #5 CLK_SYS_I = ~CLK_SYS_I;

  sft_framer dut (.CLK_SYS_I, .RST_I, .CE_I, .HSEL_I, .HADDR_I, .HTRANS_I, .HWRITE_I, .HSIZE_I, .HWDATA_I,
    .HREADY_I(HREADYOUT_O), .HRDATA_O, .HREADYOUT_O, .HRESP_O(), .TXD_O, .RXD_I, .RX_SERIAL_O, .RX_TICK_O,
    .RX_CTRL_O(RX_CTRL_O), .RX_FRAME_VALID_I, .RX_FRAME_DATA_I, .RX_ACCEPT_O, .RX_DATA_O);
  sft_peer #(.BIT_CLKS(32)) peer (.clk_i(CLK_SYS_I), .line_i(TXD_O), .line_o(RXD_I));

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // bounded wait for hready, a hang ends the run
  task automatic edge_rdy();
    for (int k = 0; k < 50; k++) begin
      @(posedge CLK_SYS_I);
      if (HREADYOUT_O === 1'h1) return;
    end
    n_errors++;
    end_sim();
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    HSEL_I <= 1'h1;
    HADDR_I <= {24'h0, a};
    HWRITE_I <= w;
    HTRANS_I <= 2'h2;
    edge_rdy();
    HTRANS_I <= 2'h0;
    HWDATA_I <= wd;
    edge_rdy();
    r = HRDATA_O;
  endtask

  task automatic frames(input int n);
    for (int k = 0; k < 4000 && peer.got.size() < n; k++) @(posedge CLK_SYS_I);
    if (peer.got.size() < n) begin
      n_errors++;
      end_sim();
    end
  endtask

  // line image of one frame: data lsb first, then stop level
  function automatic logic [9:0] frm(input logic [2:0] m, input logic o, input logic [8:0] v);
    case (m)
      MODE_8D:  return {2'h3, v[7:0]};
      MODE_7DP: return {2'h3, ^v[6:0] ^ o, v[6:0]};
      MODE_8DP: return {1'h1, ^v[7:0] ^ o, v[7:0]};
      default:  return {1'h1, v};
    endcase
  endfunction

  // main sequence
  initial begin
    void'($urandom(64249));
    repeat (8) @(posedge CLK_SYS_I);
    RST_I <= 1'h0;
    bus(1'h0, ADDR_BAUD, 32'h0);
    chk(r, {16'h0, BAUD_RESET});
    bus(1'h0, ADDR_STAT, 32'h0);
    chk(r, 32'h6);
    bus(1'h0, 8'h14, 32'h0);
    chk(r, 32'h0);
    bus(1'h1, ADDR_BAUD, 32'h2);
    bus(1'h1, ADDR_CTRL, 32'h200);
    bus(1'h1, ADDR_FLUSH, 32'h0);
    for (int i = 0; i < 17; i++) begin
      bus(1'h1, ADDR_TXW, $urandom);
      if (i == 7) begin
        bus(1'h0, ADDR_STAT, 32'h0);
        chk(r, 32'h46);
      end
    end
    bus(1'h0, ADDR_STAT, 32'h0);
    chk(r, 32'h85);
    bus(1'h1, ADDR_FLUSH, $urandom);
    bus(1'h0, ADDR_STAT, 32'h0);
    chk(r, 32'h6);
    $display("queue test done");
    // one-deep: the second write replaces the first, then run starts it
    d[0] = 9'($urandom);
    bus(1'h1, ADDR_CTRL, 32'h0);
    bus(1'h1, ADDR_FLUSH, 32'h0);
    bus(1'h1, ADDR_TXW, $urandom);
    bus(1'h1, ADDR_TXW, {23'h0, d[0]});
    bus(1'h0, ADDR_STAT, 32'h0);
    chk(r, 32'hD);
    bus(1'h1, ADDR_CTRL, 32'h59);
    frames(1);
    chk({22'h0, peer.got.pop_front()}, {22'h0, 2'h3, d[0][7:0]});
    $display("one-deep test done");
    // every format and parity, two characters back to back
    foreach (modes[m]) begin
      for (int o = 0; o < 2; o++) begin
        // odd passes also turn on loop-back
        c = 32'h358 | 32'(o << 5) | 32'(o << 7) | {29'h0, modes[m]};
        bus(1'h1, ADDR_CTRL, c);
        bus(1'h1, ADDR_FLUSH, 32'h0);
        chk({22'h0, RX_CTRL_O}, c);
        d[0] = 9'($urandom);
        d[0][8] = o[0];
        d[1] = 9'($urandom);
        bus(1'h1, ADDR_TXW, {23'h0, d[0]});
        bus(1'h1, ADDR_TXW, {23'h0, d[1]});
        // start bit reaches the receiver input only through loop-back
        for (int k = 0; k < 200 && TXD_O !== 1'h0; k++) @(posedge CLK_SYS_I);
        if (TXD_O !== 1'h0) begin
          n_errors++;
          end_sim();
        end
        #1;
        chk({31'h0, RX_SERIAL_O}, {31'h0, !o[0]});
        frames(2);
        for (int j = 0; j < 2; j++) chk({22'h0, peer.got.pop_front()}, {22'h0, frm(modes[m], o[0], d[j])});
        RX_FRAME_DATA_I <= d[0];
        RX_FRAME_VALID_I <= 1'h1;
        @(posedge CLK_SYS_I);
        RX_FRAME_VALID_I <= 1'h0;
        #1;
        chk({31'h0, RX_ACCEPT_O}, {31'h0, modes[m] != MODE_8DW || d[0][8]});
        chk({23'h0, RX_DATA_O}, {23'h0, d[0]});
        @(posedge CLK_SYS_I);
      end
    end
    // divisor two gives a tick every other clock
    nt = 0;
    repeat (32) begin
      @(posedge CLK_SYS_I);
      nt += int'(RX_TICK_O);
    end
    chk(nt, 16);
    $display("frame test done");
    end_sim();
  end
endmodule // async_serial_transmitter_framer_bench
`default_nettype wire
